// ===== shared/bmp_pkg.sv
// Constants for the boot-mode and pin-sharing block.
// Assumes a single 20 MHz core clock and byte-addressed Avalon-MM registers.
`default_nettype none
package bmp_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] REG_SYSCTRL = 5'h00;
  localparam logic [4:0] REG_FLAGDIR = 5'h04;
  localparam logic [4:0] REG_FLAGOUT = 5'h08;
  localparam logic [4:0] REG_FLAGIN = 5'h0c;
  localparam logic [4:0] REG_IRQSTAT = 5'h10;
  localparam logic [4:0] REG_INTERRUPT_MASK_REG = 5'h14;
  localparam logic [4:0] REG_MODE = 5'h18;
  // ==========================================================
  // System control field positions
  localparam int SC_SERIAL_ALT = 0;
  localparam int SC_GO_MODE = 1;
  localparam int SC_IRQA_EDGE = 2;
  localparam int SC_ALT0_EDGE = 3;
  localparam int SC_ALT1_EDGE = 4;
  localparam int SC_W = 5;
  // Flag register bit 7 is the serial alternate flag
  localparam int FL_W = 7;
  localparam int FL_ALT = 7;
  // Status bits: edge_irq, level_irq_a, level_irq_b, edge_or_level_irq_a,
  // serial_alt_irqs 0 and 1
  localparam int IRQ_W = 6;
  localparam int MODE_GRANT = 3;
  // ==========================================================
  // Reset values
  localparam logic [SC_W-1:0] SC_RST = 5'h00;
  localparam logic [FL_W:0] FLAG_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
  // ==========================================================
  // Timing: edges after reset release until mode pins are captured
  localparam logic [1:0] MODE_WAIT = 2'h3;
  // Cycles each external strobe is held low
  localparam logic [1:0] STROBE_CYC = 2'h3;
  // ==========================================================
  // External bus owner states
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_STROBE = 4'b0010,
    BUS_RELEASE = 4'b0100,
    BUS_GRANT = 4'b1000
  } bmp_bus_e;
endpackage
`default_nettype wire

// ===== rtl/bmp_pin_share.sv
// Boot-mode capture, external bus sharing, host port and flag/irq pins.
// Assumes core side signals share the clock; all pins are asynchronous.
//
// Overview of operation
// RQ1 - Mode C pin level after reset picks full memory (0) or host (1) mode.
// RQ2 - Captured mode holds until next reset; later pin changes are ignored.
// RQ3 - Mode pins are inputs only at reset, then ordinary programmable flags.
// RQ4 - Full memory mode drives a 14-bit address shared by all spaces.
// RQ5 - Full mode uses 24-bit data; top 8 bits carry byte-memory high address.
// RQ6 - Host mode: 16-bit host address/data port, one address pin, data 23:8.
// RQ7 - Host drives select, latch, read, write; device answers with acknowledge.
// RQ8 - In host mode outside logic decodes peripherals from address 0 and selects.
// RQ9 - Shared irq/flag pins raise interrupts whoever drives them, if unmasked.
// RQ10 - Control bit switches second serial port pins to irqs and flags.
// RQ11 - Bus request halts the core, except in go mode where it keeps running.
// RQ12 - Bus outputs float first; grant is asserted only after that release.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser
module bmp_sync #(parameter int W = 1) (
  input wire logic clock, // Core clock
  input wire logic rstn, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous level
  output logic [W-1:0] q // Synchronised level
);
  logic [W-1:0] meta_q;
  // Both stages preset high, the idle level of the active-low pins
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= '1;
      q <= '1;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ==========================================================
// Top module
module bmp_pin_share (
  input wire logic clock, // 20 MHz core clock
  input wire logic rstn, // Async reset, active low
  input wire logic [4:0] avAddress, // Register byte address
  input wire logic avRead, // Read request
  input wire logic avWrite, // Write request
  input wire logic [31:0] avWriteData, // Write data
  output logic [31:0] avReadData, // Read data
  output logic avWaitRequest, // Stall
  output logic irqOut, // Unmasked status pending
  input wire logic [2:0] modeFlagIn, // flag_pin_2..0 pin level
  output logic [2:0] modeFlagOut, // flag_pin_2..0 drive value
  output logic [2:0] modeFlagOeN, // flag_pin_2..0 enable, low drives
  input wire logic [3:0] irqFlagIn, // edge_irq, level_irq_a/b, edge_or_level_irq_a
  output logic [3:0] irqFlagOut, // Shared pin drive value
  output logic [3:0] irqFlagOeN, // Shared pin enable, low drives
  input wire logic [2:0] serialPinIn, // Frame rx, frame tx, data in pins
  output logic serialDataPin, // Serial data out pin
  input wire logic coreSerialOut, // Serial data from the port
  output logic [2:0] coreSerialIn, // Pins to the port, idle high in alt use
  input wire logic coreReq, // External access request, level
  input wire logic coreWrite, // Access direction
  input wire logic [1:0] coreSpace, // 0 prog, 1 data, 2 byte, 3 io
  input wire logic [13:0] coreAddr, // Access address
  input wire logic [7:0] coreByteHi, // Byte memory high address
  input wire logic [23:0] coreWrData, // Write data
  output logic [23:0] coreRdData, // Read data
  output logic coreAck, // Access done pulse
  output logic coreHalt, // Core stalled for bus grant
  output logic [13:0] extAddrOut, // ext_addr_bus value
  output logic [13:0] extAddrOeN, // ext_addr_bus enable, low drives
  input wire logic [23:0] extDataIn, // ext_data_bus level
  output logic [23:0] extDataOut, // ext_data_bus value
  output logic [23:0] extDataOeN, // ext_data_bus enable, low drives
  output logic [4:0] spaceSelN, // prog, data, byte, io, combined selects
  output logic readStrobeN, // Read enable out
  output logic writeStrobeN, // Write enable out
  output logic ctlOeN, // Enable of selects and strobes, low drives
  input wire logic busRequestN, // bus_request_in
  output logic busGrantN, // bus_grant_out
  output logic busGrantHungN, // bus_grant_hung_out
  input wire logic hostPortSelN, // host_port_select
  input wire logic hostAddrLatch, // host_addr_latch, active high
  input wire logic hostReadStrobeN, // host_read_strobe
  input wire logic hostWriteStrobeN, // host_write_strobe
  output logic hostPortAckN, // host_port_ack, low when ready
  input wire logic [15:0] hostBusIn, // host_addr_data_bus level
  output logic [15:0] hostBusOut, // host_addr_data_bus value
  output logic hostBusOeN, // host_addr_data_bus enable, low drives
  output logic hostMemRd, // On-chip read pulse
  output logic hostMemWr, // On-chip write pulse
  output logic [13:0] hostMemAddr, // On-chip address
  output logic [15:0] hostMemWrData, // On-chip write data
  input wire logic [15:0] hostMemRdData // On-chip read data, next cycle
);
  // ==========================================================
  // Pin synchronisers
  logic [2:0] mfS;
  logic [3:0] ifS;
  logic [2:0] spS;
  logic brS;
  logic [3:0] hcS;
  logic [15:0] hbS;
  logic [23:0] edS;
  bmp_sync #(.W(55)) uSync (
    .clock(clock),
    .rstn(rstn),
    .d({modeFlagIn, irqFlagIn, serialPinIn, busRequestN, hostPortSelN,
        hostAddrLatch, hostReadStrobeN, hostWriteStrobeN, hostBusIn, extDataIn}),
    .q({mfS, ifS, spS, brS, hcS, hbS, edS})
  );

  // ==========================================================
  // Mode capture
  logic [1:0] modeCnt_q, modeCnt_d;
  logic modeOk_q, modeOk_d;
  logic [2:0] mode_q, mode_d;
  logic hostMode;
  // Pins settle through the synchroniser before the one capture
  always_comb
  begin
    modeCnt_d = modeCnt_q;
    modeOk_d = modeOk_q;
    mode_d = mode_q;
    if (!modeOk_q)
    begin
      modeCnt_d = modeCnt_q + 2'h1;
      if (modeCnt_q == bmp_pkg::MODE_WAIT - 2'h1)
      begin
        modeOk_d = 1'b1; // RQ2
        mode_d = mfS; // RQ1
      end
    end
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      modeCnt_q <= 2'h0;
      modeOk_q <= 1'b0;
      mode_q <= 3'h0;
    end
    else
    begin
      modeCnt_q <= modeCnt_d;
      modeOk_q <= modeOk_d;
      mode_q <= mode_d;
    end
  end
  assign hostMode = mode_q[2];

  // ==========================================================
  // Register bus and registers
  logic [bmp_pkg::SC_W-1:0] sc_q, sc_d;
  logic [bmp_pkg::FL_W:0] fdir_q, fdir_d, fout_q, fout_d;
  logic [bmp_pkg::IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
  logic [3:0] ifP_q;
  logic [1:0] spP_q;
  logic wait_q, wait_d, irq_d, done;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] flagIn;
  assign done = (avRead || avWrite) && !wait_q;
  assign flagIn = {spS[2], ifS, mfS};
  // Interrupt events from shared and alternate pins
  always_comb
  begin
    ev[0] = ifP_q[0] && !ifS[0];
    ev[1] = !ifS[1];
    ev[2] = !ifS[2];
    ev[3] = sc_q[bmp_pkg::SC_IRQA_EDGE] ? (ifP_q[3] && !ifS[3]) : !ifS[3]; // RQ9
    ev[4] = sc_q[bmp_pkg::SC_SERIAL_ALT] &&
            (sc_q[bmp_pkg::SC_ALT0_EDGE] ? (spP_q[0] && !spS[0]) : !spS[0]); // RQ10
    ev[5] = sc_q[bmp_pkg::SC_SERIAL_ALT] &&
            (sc_q[bmp_pkg::SC_ALT1_EDGE] ? (spP_q[1] && !spS[1]) : !spS[1]); // RQ10
  end
  // One wait state, then write or read-clear at the completing edge
  always_comb
  begin
    wait_d = !((avRead || avWrite) && wait_q);
    sc_d = sc_q;
    fdir_d = fdir_q;
    fout_d = fout_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (done && avRead && avAddress == bmp_pkg::REG_IRQSTAT)
    begin
      stat_d = 6'h00;
    end
    stat_d = stat_d | ev; // RQ9
    if (done && avWrite)
    begin
      unique case (avAddress)
        bmp_pkg::REG_SYSCTRL: sc_d = avWriteData[bmp_pkg::SC_W-1:0]; // RQ10
        bmp_pkg::REG_FLAGDIR: fdir_d = avWriteData[bmp_pkg::FL_W:0]; // RQ3
        bmp_pkg::REG_FLAGOUT: fout_d = avWriteData[bmp_pkg::FL_W:0];
        bmp_pkg::REG_INTERRUPT_MASK_REG: mask_d = avWriteData[bmp_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    rdat_d = 32'h0;
    unique case (avAddress)
      bmp_pkg::REG_SYSCTRL: rdat_d[bmp_pkg::SC_W-1:0] = sc_q;
      bmp_pkg::REG_FLAGDIR: rdat_d[bmp_pkg::FL_W:0] = fdir_q;
      bmp_pkg::REG_FLAGOUT: rdat_d[bmp_pkg::FL_W:0] = fout_q;
      bmp_pkg::REG_FLAGIN: rdat_d[bmp_pkg::FL_W:0] = flagIn;
      bmp_pkg::REG_IRQSTAT: rdat_d[bmp_pkg::IRQ_W-1:0] = stat_q;
      bmp_pkg::REG_INTERRUPT_MASK_REG: rdat_d[bmp_pkg::IRQ_W-1:0] = mask_q;
      bmp_pkg::REG_MODE: rdat_d[bmp_pkg::MODE_GRANT:0] = {!busGrantN, mode_q};
      default: ;
    endcase
    irq_d = |(stat_d & mask_d); // RQ9
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_q <= 1'b1;
      sc_q <= bmp_pkg::SC_RST;
      fdir_q <= bmp_pkg::FLAG_RST;
      fout_q <= bmp_pkg::FLAG_RST;
      stat_q <= bmp_pkg::IRQ_RST;
      mask_q <= bmp_pkg::IRQ_RST;
      ifP_q <= 4'hf;
      spP_q <= 2'h3;
      rdat_q <= 32'h0;
      irqOut <= 1'b0;
    end
    else
    begin
      wait_q <= wait_d;
      sc_q <= sc_d;
      fdir_q <= fdir_d;
      fout_q <= fout_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      ifP_q <= ifS;
      spP_q <= spS[1:0];
      rdat_q <= rdat_d;
      irqOut <= irq_d;
    end
  end
  assign avWaitRequest = wait_q;
  assign avReadData = rdat_q;

  // ==========================================================
  // Flag and serial pin drive
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      modeFlagOut <= 3'h0;
      modeFlagOeN <= 3'h7;
      irqFlagOut <= 4'h0;
      irqFlagOeN <= 4'hf;
      serialDataPin <= 1'b0;
      coreSerialIn <= 3'h7;
    end
    else
    begin
      modeFlagOut <= fout_q[2:0];
      modeFlagOeN <= ~(fdir_q[2:0] & {3{modeOk_q}}); // RQ3
      irqFlagOut <= fout_q[6:3];
      irqFlagOeN <= ~fdir_q[6:3]; // RQ9
      serialDataPin <= sc_q[bmp_pkg::SC_SERIAL_ALT] ? fout_q[bmp_pkg::FL_ALT]
                                                     : coreSerialOut; // RQ10
      coreSerialIn <= sc_q[bmp_pkg::SC_SERIAL_ALT] ? 3'h7 : spS; // RQ10
    end
  end

  // ==========================================================
  // External bus owner state machine
  bmp_pkg::bmp_bus_e st_q, st_d;
  logic [1:0] cnt_q, cnt_d;
  logic ack_d, drive;
  logic [23:0] rd_d, dOut, dOe;
  logic [4:0] sel;
  always_comb
  begin
    st_d = st_q;
    cnt_d = 2'h0;
    ack_d = 1'b0;
    rd_d = coreRdData;
    unique case (st_q)
      bmp_pkg::BUS_IDLE:
        if (!brS && modeOk_q)
          st_d = bmp_pkg::BUS_RELEASE; // RQ11
        else if (coreReq && modeOk_q)
          st_d = bmp_pkg::BUS_STROBE;
      bmp_pkg::BUS_STROBE:
      begin
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == bmp_pkg::STROBE_CYC - 2'h1)
        begin
          st_d = bmp_pkg::BUS_IDLE;
          ack_d = 1'b1;
          if (hostMode)
            rd_d = (coreSpace == 2'h2) ? {16'h0, edS[15:8]} : {8'h0, edS[23:8]}; // RQ6
          else
            rd_d = (coreSpace == 2'h2) ? {16'h0, edS[7:0]} : edS; // RQ5
        end
      end
      bmp_pkg::BUS_RELEASE: st_d = bmp_pkg::BUS_GRANT; // RQ12
      bmp_pkg::BUS_GRANT:
        if (brS)
          st_d = bmp_pkg::BUS_IDLE;
    endcase
  end
  // Drivers return one cycle after the grant is withdrawn
  assign drive = modeOk_q && st_d != bmp_pkg::BUS_RELEASE &&
                 st_d != bmp_pkg::BUS_GRANT && st_q != bmp_pkg::BUS_GRANT; // RQ12
  // Pin values for the access in progress
  always_comb
  begin
    dOut = coreWrData;
    dOe = coreWrite ? 24'hffffff : 24'h0;
    if (hostMode)
    begin
      dOut = {coreWrData[15:0], 8'h0}; // RQ6
      dOe[7:0] = 8'h0;
      if (coreSpace == 2'h2)
      begin
        dOut = {coreByteHi, coreWrData[7:0], 8'h0};
        dOe[23:16] = 8'hff;
      end
    end
    else if (coreSpace == 2'h2)
    begin
      dOut = {coreByteHi, 8'h0, coreWrData[7:0]}; // RQ5
      dOe[23:16] = 8'hff;
    end
    sel = 5'h1f;
    if (st_d == bmp_pkg::BUS_STROBE)
    begin
      sel[coreSpace] = 1'b0; // RQ8
      sel[4] = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= bmp_pkg::BUS_IDLE;
      cnt_q <= 2'h0;
      coreAck <= 1'b0;
      coreRdData <= 24'h0;
      coreHalt <= 1'b0;
      extAddrOut <= 14'h0;
      extAddrOeN <= 14'h3fff;
      extDataOut <= 24'h0;
      extDataOeN <= 24'hffffff;
      spaceSelN <= 5'h1f;
      readStrobeN <= 1'b1;
      writeStrobeN <= 1'b1;
      ctlOeN <= 1'b1;
      busGrantN <= 1'b1;
      busGrantHungN <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      coreAck <= ack_d;
      coreRdData <= rd_d;
      coreHalt <= !sc_q[bmp_pkg::SC_GO_MODE] && !drive && modeOk_q; // RQ11
      extAddrOut <= coreAddr;
      extAddrOeN <= ~({{13{!hostMode}}, 1'b1} & {14{drive}}); // RQ4
      extDataOut <= dOut;
      extDataOeN <= ~(dOe & {24{drive && st_d == bmp_pkg::BUS_STROBE}}); // RQ5
      spaceSelN <= sel;
      readStrobeN <= !(st_d == bmp_pkg::BUS_STROBE && !coreWrite);
      writeStrobeN <= !(st_d == bmp_pkg::BUS_STROBE && coreWrite);
      ctlOeN <= !drive; // RQ12
      busGrantN <= st_d != bmp_pkg::BUS_GRANT; // RQ12
      busGrantHungN <= !(st_d == bmp_pkg::BUS_GRANT && coreReq); // RQ11
    end
  end

  // ==========================================================
  // Host port, active only in host mode
  logic [3:0] hcP_q;
  logic hostRd_d, hostWr_d, busy_q;
  logic [13:0] hAddr_d;
  logic hostRd_q;
  assign hostRd_d = hostMode && !hcS[3] && hcP_q[1] && !hcS[1]; // RQ7
  assign hostWr_d = hostMode && !hcS[3] && hcP_q[0] && !hcS[0]; // RQ7
  // Latch on the address strobe, step after each data access
  always_comb
  begin
    hAddr_d = hostMemAddr;
    if (hostMode && !hcS[3] && hcS[2] && !hcP_q[2])
      hAddr_d = hbS[13:0]; // RQ6
    else if (hostRd_q || hostMemWr)
      hAddr_d = hostMemAddr + 14'h1;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      hcP_q <= 4'hb;
      busy_q <= 1'b0;
      hostRd_q <= 1'b0;
      hostMemRd <= 1'b0;
      hostMemWr <= 1'b0;
      hostMemAddr <= 14'h0;
      hostMemWrData <= 16'h0;
      hostBusOut <= 16'h0;
      hostBusOeN <= 1'b1;
      hostPortAckN <= 1'b1;
    end
    else
    begin
      hcP_q <= hcS;
      busy_q <= hostRd_d || hostWr_d;
      hostRd_q <= hostMemRd;
      hostMemRd <= hostRd_d;
      hostMemWr <= hostWr_d;
      hostMemAddr <= hAddr_d;
      hostMemWrData <= hbS;
      hostBusOut <= hostRd_q ? hostMemRdData : hostBusOut;
      hostBusOeN <= !(hostMode && !hcS[3] && !hcS[1]); // RQ6
      hostPortAckN <= !(hostMode && modeOk_q && !busy_q && !hostRd_d &&
                        !hostWr_d && !hostMemRd); // RQ7
    end
  end
endmodule
`default_nettype wire

// ===== test/bmp_ext_mem.sv
// External memory model on the shared bus of the pin-sharing block.
// Assumes it sees the block's bus pins directly and shares its clock.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Memory answering reads at once from the address
module bmp_ext_mem (
  input wire logic clock, // Core clock
  input wire logic [13:0] extAddrOut, // Address pins
  input wire logic [4:0] spaceSelN, // Space selects
  input wire logic readStrobeN, // Read enable
  input wire logic ctlOeN, // Select and strobe drive enable
  output logic [23:0] extDataIn // Data pins as the block sees them
);
  logic [23:0] stale_q = 24'h000000;
  logic hit;
  // Decode from the combined select and the read strobe
  assign hit = !ctlOeN && !readStrobeN && !spaceSelN[4];
  // A released bus shows a pattern that flips every cycle
  always_ff @(posedge clock)
  begin
    stale_q <= ~stale_q;
  end
  assign extDataIn = hit ? {~extAddrOut[9:0], extAddrOut} : stale_q;
endmodule
`default_nettype wire

// ===== test/bmp_pin_share_props.sv
// Checker for the pin-sharing block, bound to its top module.
// Assumes one clock and an asynchronous active low reset.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// External bus, grant and host write pulse properties
module bmp_pin_share_props (
  input wire logic clock, // Core clock
  input wire logic rstn, // Reset, active low
  input wire logic [13:0] extAddrOut, // Address value
  input wire logic [13:0] extAddrOeN, // Address enable
  input wire logic [23:0] extDataOeN, // Data enable
  input wire logic [4:0] spaceSelN, // Space selects
  input wire logic readStrobeN, // Read enable
  input wire logic writeStrobeN, // Write enable
  input wire logic ctlOeN, // Control enable
  input wire logic busGrantN, // Grant out
  input wire logic coreAck, // Access done
  input wire logic hostMemWr // Host write pulse
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Read strobe held low three cycles, then released with the done pulse
  sequence readLow;
    !readStrobeN [*3];
  endsequence
  sequence readEnd;
    readStrobeN && coreAck;
  endsequence
  a_read_strobe_len: assert property ($fell(readStrobeN) |-> readLow ##1 readEnd)
    else $error("read strobe length wrong");
  a_addr_stable: assert property
    (!readStrobeN && $past(readStrobeN) == 1'b0 |-> $stable(extAddrOut))
    else $error("address moved during read");
  a_write_drive: assert property
    (!writeStrobeN |-> extDataOeN[23:16] == 8'h00 && !extAddrOeN[0])
    else $error("write data not driven");
  a_read_float: assert property
    (!readStrobeN && spaceSelN[2] |-> extDataOeN == 24'hffffff)
    else $error("data driven during read");
  a_sel_onehot: assert property
    (!readStrobeN || !writeStrobeN |-> !spaceSelN[4] && $onehot(~spaceSelN[3:0]))
    else $error("space selects wrong");
  a_ack_after_strobe: assert property
    (coreAck |-> $past(readStrobeN) == 1'b0 || $past(writeStrobeN) == 1'b0)
    else $error("done without a strobe");
  a_grant_floats: assert property
    (!busGrantN |-> &extAddrOeN && &extDataOeN && ctlOeN)
    else $error("bus driven while granted");
  a_grant_late: assert property
    ($fell(busGrantN) |-> $past(ctlOeN) == 1'b1 && $past(extAddrOeN) == 14'h3fff)
    else $error("grant before release");
  a_host_wr_pulse: assert property
    (hostMemWr |=> !hostMemWr)
    else $error("host write pulse too long");
endmodule
bind bmp_pin_share bmp_pin_share_props props (
  .clock(clock), .rstn(rstn), .extAddrOut(extAddrOut), .extAddrOeN(extAddrOeN),
  .extDataOeN(extDataOeN), .spaceSelN(spaceSelN), .readStrobeN(readStrobeN),
  .writeStrobeN(writeStrobeN), .ctlOeN(ctlOeN), .busGrantN(busGrantN),
  .coreAck(coreAck), .hostMemWr(hostMemWr)
);
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench: mode capture, flags, core bus, irqs, grant, host port.
// Assumes the external memory model and the bound property checker.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock = 1'b0, rstn = 1'b0, avRead = 1'b0, avWrite = 1'b0;
  logic [4:0] avAddress = 5'h00, spaceSelN;
  logic [31:0] avWriteData = 32'h0, avReadData;
  logic avWaitRequest, irqOut, serialDataPin, coreAck, coreHalt, readStrobeN, writeStrobeN;
  logic ctlOeN, busGrantN, busGrantHungN, hostPortAckN, hostBusOeN, hostMemRd, hostMemWr;
  logic [2:0] modeExt = 3'h0, modeFlagIn, modeFlagOut, modeFlagOeN, coreSerialIn;
  logic [2:0] serialPinIn = 3'h7;
  logic [3:0] irqExt = 4'hf, irqFlagIn, irqFlagOut, irqFlagOeN;
  logic coreSerialOut = 1'b0, coreReq = 1'b0, coreWrite = 1'b0, busRequestN = 1'b1;
  logic hostPortSelN = 1'b1, hostAddrLatch = 1'b0, hostReadStrobeN = 1'b1;
  logic hostWriteStrobeN = 1'b1;
  logic [1:0] coreSpace = 2'h0;
  logic [13:0] coreAddr = 14'h0, extAddrOut, extAddrOeN, hostMemAddr, eA;
  logic [7:0] coreByteHi = 8'h00;
  logic [23:0] coreWrData = 24'h0, coreRdData, extDataIn, extDataOut, extDataOeN, eD, eOe;
  logic [15:0] hostBusIn = 16'h0, hostBusOut, hostMemWrData, hostMemRdData = 16'h0;
  int n_fail = 0, tests_run = 0, cycles = 0;
  // ==========================================================
  // Pin levels resolved from block and board drivers
  assign modeFlagIn = (modeFlagOeN & modeExt) | (~modeFlagOeN & modeFlagOut);
  assign irqFlagIn = (irqFlagOeN & irqExt) | (~irqFlagOeN & irqFlagOut);
  // Every port meets the bench signal of the same name
  bmp_pin_share uut (.*);
  bmp_ext_mem mem (.clock(clock), .extAddrOut(extAddrOut), .spaceSelN(spaceSelN),
    .readStrobeN(readStrobeN), .ctlOeN(ctlOeN), .extDataIn(extDataIn));
  // ==========================================================
  // Clock, hang limit and shared tasks
  initial
  begin
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One register access; the request holds until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avAddress <= a;
    avWrite <= w;
    avRead <= !w;
    avWriteData <= d;
    do
      @(posedge clock);
    while (avWaitRequest !== 1'b0);
    q = avReadData;
    avRead <= 1'b0;
    avWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string w, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(w, q, e);
  endtask
  // Core access; the request drops on the edge that ends the strobe
  task automatic acc(input logic w, input logic [1:0] s, input logic [13:0] a,
    input logic [23:0] d);
    int k;
    k = 0;
    coreReq <= 1'b1;
    coreWrite <= w;
    coreSpace <= s;
    coreAddr <= a;
    coreWrData <= d;
    while (k < int'(bmp_pkg::STROBE_CYC))
    begin
      @(posedge clock);
      if ((w ? writeStrobeN : readStrobeN) === 1'b0)
      begin
        if (k == 0)
        begin
          eA = extAddrOut;
          eD = extDataOut;
          eOe = extDataOeN;
        end
        k++;
      end
    end
    coreReq <= 1'b0;
    @(negedge clock);
    chk("core ack", coreAck, 32'h1);
    @(posedge clock);
  endtask
  // Bus taken by an outside master and handed back
  task automatic grant(input logic halt);
    busRequestN <= 1'b0;
    while (busGrantN !== 1'b0)
      @(posedge clock);
    chk("drivers off", {ctlOeN, extAddrOeN}, 32'h7fff);
    chk("halt", coreHalt, halt);
    busRequestN <= 1'b1;
    while (busGrantN !== 1'b1)
      @(posedge clock);
    wt(2);
  endtask
  // ==========================================================
  // Test sequence
  initial
  begin
    wt(12);
    rstn <= 1'b1;
    wt(6);
    rd("mode", bmp_pkg::REG_MODE, 32'h0);
    modeExt <= 3'b101;
    wt(4);
    rd("mode held", bmp_pkg::REG_MODE, 32'h0);
    rd("unmapped", 5'h1c, 32'h0);
    wr(bmp_pkg::REG_FLAGDIR, 32'h7);
    wr(bmp_pkg::REG_FLAGOUT, 32'h2);
    wt(2);
    chk("flag oe", modeFlagOeN, 32'h0);
    chk("flag out", modeFlagOut, 32'h2);
    rd("flag dir", bmp_pkg::REG_FLAGDIR, 32'h7);
    $display("test mode and flags done");
    for (int s = 0; s < 4; s++)
    begin
      acc(1'b1, 2'(s), 14'h1555, 24'hc3a5f0);
      chk("write addr", eA, 32'h1555);
      chk("write data", eD, s == 2 ? 32'hf0 : 32'hc3a5f0);
    end
    acc(1'b0, 2'h0, 14'h0155, 24'h0);
    chk("read data", coreRdData, {10'h2aa, 14'h0155});
    coreByteHi <= 8'h3c;
    acc(1'b0, 2'h2, 14'h0abc, 24'h0);
    chk("byte high", {eOe[23:16], eD[23:16]}, 32'h003c);
    chk("byte data", coreRdData[7:0], 32'hbc);
    $display("test full memory bus done");
    wr(bmp_pkg::REG_INTERRUPT_MASK_REG, 32'h1);
    irqExt <= 4'he;
    wt(6);
    chk("irq edge", irqOut, 32'h1);
    rd("stat edge", bmp_pkg::REG_IRQSTAT, 32'h1);
    irqExt <= 4'hf;
    wt(4);
    rd("stat clear", bmp_pkg::REG_IRQSTAT, 32'h0);
    chk("irq low", irqOut, 32'h0);
    wr(bmp_pkg::REG_FLAGDIR, 32'h10);
    wr(bmp_pkg::REG_FLAGOUT, 32'h0);
    wt(6);
    chk("irq masked", irqOut, 32'h0);
    rd("stat own flag", bmp_pkg::REG_IRQSTAT, 32'h2);
    wr(bmp_pkg::REG_INTERRUPT_MASK_REG, 32'h2);
    wt(2);
    chk("irq own flag", irqOut, 32'h1);
    wr(bmp_pkg::REG_FLAGOUT, 32'h10);
    wt(6);
    rd("stat sticky", bmp_pkg::REG_IRQSTAT, 32'h2);
    wt(2);
    chk("irq cleared", irqOut, 32'h0);
    $display("test shared irq pins done");
    coreSerialOut <= 1'b1;
    wr(bmp_pkg::REG_SYSCTRL, 32'h1);
    wt(4);
    chk("alt serial in", coreSerialIn, 32'h7);
    chk("alt flag out", serialDataPin, 32'h0);
    serialPinIn <= 3'b110;
    wt(6);
    rd("alt irq", bmp_pkg::REG_IRQSTAT, 32'h10);
    serialPinIn <= 3'b111;
    wr(bmp_pkg::REG_SYSCTRL, 32'h0);
    wt(4);
    chk("serial data", serialDataPin, 32'h1);
    $display("test serial alternate use done");
    grant(1'b1);
    wr(bmp_pkg::REG_SYSCTRL, 32'h2);
    grant(1'b0);
    $display("test bus grant done");
    modeExt <= 3'b100;
    rstn <= 1'b0;
    wt(12);
    rstn <= 1'b1;
    wt(6);
    rd("host mode", bmp_pkg::REG_MODE, 32'h4);
    acc(1'b1, 2'h3, 14'h0001, 24'h00a5a5);
    chk("host low data", eOe[7:0], 32'hff);
    hostPortSelN <= 1'b0;
    hostBusIn <= 16'h0012;
    hostAddrLatch <= 1'b1;
    wt(3);
    hostAddrLatch <= 1'b0;
    hostBusIn <= 16'hbeef;
    hostWriteStrobeN <= 1'b0;
    while (hostMemWr !== 1'b1)
      @(posedge clock);
    chk("host addr", hostMemAddr, 32'h0012);
    chk("host data", hostMemWrData, 32'hbeef);
    hostWriteStrobeN <= 1'b1;
    hostPortSelN <= 1'b1;
    wt(4);
    $display("test host mode done");
    give_verdict();
  end
endmodule
`default_nettype wire
